// *** rtl/dual_buck_ctrl.sv ***
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Two independent buck channels, each with own switch, peak and off time.
// R2: Per-channel bit enables one power-stage half, or both in low-resistance.
// R3: Mode bit selects the low or high analog peak current range.
// R4: Every switching period begins by turning the switch on.
// R5: Switch stays on through blank time even if peak reached early.
// R6: After blank time, switch turns off when sensed current hits peak.
// R7: Six-bit peak targets come from bits 23:18 and 17:12.
// R8: Off time follows four-bit ripple constants in bits 11:8 and 7:4.
// R9: A minimum off time is forced every cycle for bootstrap recharge.
// R10: Input-voltage window fields at bits 5:4 and 3:2 go to sensing.
// R11: Output-short detection is suppressed during a channel's start-up.
// R12: Start-up applies on first activation after reset or wake.
// R13: Start-up applies after idle longer than the restart delay.
// R14: Start-up applies when a latched-off channel is cleared and restarts.
// R15: Start-up applies on reactivation after supply undervoltage.
// R16: Dimming picks the direct input or a 10-bit internal PWM.
// R17: Internal PWM advances on the dimming clock input.
// R18: Serial input sampled on rising clock, output shifted on falling.
// R19: Blank, off, start-up and idle times are parameterised counters.
// R20: Each channel owns its start-up and idle timers, restarted on triggers.
module dual_buck_ctrl #(
  parameter int BLANK_CYC     = dual_buck_pkg::BLANK_CYC,
  parameter int TOFF_MIN_CYC  = dual_buck_pkg::TOFF_MIN_CYC,
  parameter int TOFF_STEP_CYC = dual_buck_pkg::TOFF_STEP_CYC,
  parameter int STARTUP_CYC   = dual_buck_pkg::STARTUP_CYC,
  parameter int IDLE_CYC      = dual_buck_pkg::IDLE_CYC,
  parameter int PWM_BITS      = dual_buck_pkg::PWM_BITS
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic [7:0]                 s_axi_awaddr_i,
  input  wire logic                       s_axi_awvalid_i,
  output logic                            s_axi_awready_o,
  input  wire logic [31:0]                s_axi_wdata_i,
  input  wire logic [3:0]                 s_axi_wstrb_i,
  input  wire logic                       s_axi_wvalid_i,
  output logic                            s_axi_wready_o,
  output logic [1:0]                      s_axi_bresp_o,
  output logic                            s_axi_bvalid_o,
  input  wire logic                       s_axi_bready_i,
  input  wire logic [7:0]                 s_axi_araddr_i,
  input  wire logic                       s_axi_arvalid_i,
  output logic                            s_axi_arready_o,
  output logic [31:0]                     s_axi_rdata_o,
  output logic [1:0]                      s_axi_rresp_o,
  output logic                            s_axi_rvalid_o,
  input  wire logic                       s_axi_rready_i,
  input  wire logic [1:0]                 peak_hit_i,
  input  wire logic [1:0]                 short_det_i,
  input  wire logic                       vs_uv_i,
  input  wire logic                       direct_dim_i,
  input  wire logic                       dimming_clock_input_i,
  input  wire logic                       serial_select_low_i,
  input  wire logic                       serial_clk_i,
  input  wire logic                       serial_data_i,
  output logic                            serial_data_o,
  output logic [1:0]                      switch_on_o,
  output logic [1:0][1:0]                 half_en_o,
  output dual_buck_pkg::ch_cfg_t [1:0]    ch_cfg_o,
  output logic [1:0]                      short_latched_o,
  output logic [1:0]                      startup_o
);

  logic [31:0]           cr1_reg, cr2_reg, cr3_reg, ctl_reg, spi_rx_reg;
  logic [31:0]           rd_word;
  logic                  aw_hold_reg, w_hold_reg, rd_hit;
  logic [7:0]            awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  do_wr, wr_hit;
  logic [1:0]            latch_clr, act, trig, need, su_act;
  logic [1:0]            act_q_reg, started_reg, uv_pend_reg, clr_pend_reg;
  logic [1:0]            latched_reg;
  dual_buck_pkg::sw_state_t st_reg [2];
  logic [15:0]           cnt_reg [2];
  logic [15:0]           su_cnt_reg [2];
  logic [15:0]           idle_cnt_reg [2];
  logic [PWM_BITS-1:0]   pwm_cnt_reg;
  logic                  dclk_q_reg, sclk_q_reg, cs_q_reg, dim;
  logic [31:0]           spi_sh_reg, spi_tx_reg;

  // Byte-lane merge for AXI writes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data held apart so either may come first
  assign s_axi_awready_o = ce_i && !aw_hold_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = ce_i && !w_hold_reg && !s_axi_bvalid_o;
  assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;
  assign do_wr = ce_i && aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;
  assign wr_hit = awaddr_reg inside {dual_buck_pkg::ADDR_CR1,
    dual_buck_pkg::ADDR_CR2, dual_buck_pkg::ADDR_CR3,
    dual_buck_pkg::ADDR_CTL, dual_buck_pkg::ADDR_STATUS};

  // Write channel capture and response
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_hold_reg    <= 1'b0;
      w_hold_reg     <= 1'b0;
      awaddr_reg     <= 8'h00;
      wdata_reg      <= 32'h00000000;
      wstrb_reg      <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= dual_buck_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata_i;
        wstrb_reg  <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_hold_reg    <= 1'b0;
        w_hold_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? dual_buck_pkg::RESP_OKAY
                                 : dual_buck_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Register storage; config registers steer the channels
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cr1_reg <= dual_buck_pkg::REG_RST;
      cr2_reg <= dual_buck_pkg::REG_RST;
      cr3_reg <= dual_buck_pkg::REG_RST;
      ctl_reg <= dual_buck_pkg::REG_RST;
    end else if (ce_i && do_wr) begin
      case (awaddr_reg)
        dual_buck_pkg::ADDR_CR1: cr1_reg <= dual_buck_pkg::CR1_MASK &
          wmerge(cr1_reg, wdata_reg, wstrb_reg);
        dual_buck_pkg::ADDR_CR2: cr2_reg <= dual_buck_pkg::CR2_MASK &
          wmerge(cr2_reg, wdata_reg, wstrb_reg);
        dual_buck_pkg::ADDR_CR3: cr3_reg <= dual_buck_pkg::CR3_MASK &
          wmerge(cr3_reg, wdata_reg, wstrb_reg);
        dual_buck_pkg::ADDR_CTL: ctl_reg <= dual_buck_pkg::CTL_MASK &
          wmerge(ctl_reg, wdata_reg, wstrb_reg);
        default: ;
      endcase
    end
  end

  // Read mux; status shows live channel state
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr_i)
      dual_buck_pkg::ADDR_CR1:    rd_word = cr1_reg;
      dual_buck_pkg::ADDR_CR2:    rd_word = cr2_reg;
      dual_buck_pkg::ADDR_CR3:    rd_word = cr3_reg;
      dual_buck_pkg::ADDR_CTL:    rd_word = ctl_reg;
      dual_buck_pkg::ADDR_STATUS:
        rd_word = {25'h0000000, dim, switch_on_o, su_act, latched_reg};
      dual_buck_pkg::ADDR_SPI_RX: rd_word = spi_rx_reg;
      default:                    rd_hit  = 1'b0;
    endcase
  end

  // Read channel
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= dual_buck_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_word;
        s_axi_rresp_o  <= rd_hit ? dual_buck_pkg::RESP_OKAY
                                 : dual_buck_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Dimming: PWM steps on each rising edge of the dimming clock pin seen while ce_i is high
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dclk_q_reg  <= 1'b0;
      pwm_cnt_reg <= '0;
    end else if (ce_i) begin
      dclk_q_reg <= dimming_clock_input_i;
      if (dimming_clock_input_i && !dclk_q_reg) begin
        pwm_cnt_reg <= pwm_cnt_reg + 1'b1; // see R17
      end
    end
  end

  // Source select; duty of zero keeps the string dark
  assign dim = ctl_reg[dual_buck_pkg::CTL_DSEL_POS]
    ? (pwm_cnt_reg < ctl_reg[dual_buck_pkg::CTL_DUTY_LSB +: PWM_BITS])
    : direct_dim_i; // see R16

  ////////////////////////////////////////////////////////////////////////
  // Serial port: pins sampled on the system clock, edges found locally
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sclk_q_reg    <= 1'b0;
      cs_q_reg      <= 1'b1;
      spi_sh_reg    <= 32'h00000000;
      spi_tx_reg    <= 32'h00000000;
      spi_rx_reg    <= 32'h00000000;
      serial_data_o <= 1'b0;
    end else if (ce_i) begin
      sclk_q_reg <= serial_clk_i;
      cs_q_reg   <= serial_select_low_i;
      if (cs_q_reg && !serial_select_low_i) begin
        spi_tx_reg    <= {24'h000000, 1'b0, dim, switch_on_o, su_act,
                          latched_reg};
        serial_data_o <= 1'b0;
      end else if (!serial_select_low_i) begin
        if (serial_clk_i && !sclk_q_reg) begin
          spi_sh_reg <= {spi_sh_reg[30:0], serial_data_i}; // see R18
        end
        if (!serial_clk_i && sclk_q_reg) begin
          serial_data_o <= spi_tx_reg[31]; // see R18
          spi_tx_reg    <= {spi_tx_reg[30:0], 1'b0};
        end
      end
      // Frame end publishes the received word
      if (!cs_q_reg && serial_select_low_i) spi_rx_reg <= spi_sh_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buck channels, identical and fully independent
  for (genvar i = 0; i < 2; i++) begin : g_ch // see R1
    logic [15:0] off_len;
    logic        idle_long;

    // Off time grows with the ripple constant above a fixed floor
    assign off_len = 16'(TOFF_MIN_CYC) + 16'(ch_cfg_o[i].ripple_constant)
                     * 16'(TOFF_STEP_CYC); // see R8, R9
    assign idle_long = idle_cnt_reg[i] >= 16'(IDLE_CYC);
    assign act[i]  = ctl_reg[dual_buck_pkg::CTL_EN_LSB + i] && dim &&
                     !latched_reg[i] && !vs_uv_i;
    assign need[i] = !started_reg[i] || idle_long || uv_pend_reg[i] ||
                     clr_pend_reg[i]; // see R12, R13, R14, R15
    assign trig[i] = act[i] && !act_q_reg[i] && need[i];
    assign su_act[i] = su_cnt_reg[i] != 16'h0000;
    assign latch_clr[i] = do_wr && wstrb_reg[0] && wdata_reg[i] &&
                          awaddr_reg == dual_buck_pkg::ADDR_STATUS;
    assign switch_on_o[i] = st_reg[i] == dual_buck_pkg::ST_BLANK ||
                            st_reg[i] == dual_buck_pkg::ST_SENSE;
    assign half_en_o[i] = switch_on_o[i] ? {ch_cfg_o[i].low_rds, 1'b1}
                                         : 2'b00; // see R2, R3
    assign startup_o[i] = su_act[i];
    assign short_latched_o[i] = latched_reg[i];

    // Settings registered for the analog side
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        ch_cfg_o[i] <= '0;
      end else if (ce_i) begin
        ch_cfg_o[i].peak_current_target <=
          cr2_reg[dual_buck_pkg::PEAK_LSB[i] +: 6]; // see R7
        ch_cfg_o[i].ripple_constant <=
          cr2_reg[dual_buck_pkg::RIPL_LSB[i] +: 4]; // see R8
        ch_cfg_o[i].vin_window <=
          cr3_reg[dual_buck_pkg::WIN_LSB[i] +: 2]; // see R10
        ch_cfg_o[i].low_rds <= cr1_reg[dual_buck_pkg::RDS_POS[i]];
      end
    end

    // Switching cycle: on, blank, sense, off
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        st_reg[i]  <= dual_buck_pkg::ST_IDLE;
        cnt_reg[i] <= 16'h0000;
      end else if (ce_i) begin
        case (st_reg[i])
          dual_buck_pkg::ST_IDLE: if (act[i]) begin
            st_reg[i]  <= dual_buck_pkg::ST_BLANK; // see R4
            cnt_reg[i] <= 16'(BLANK_CYC - 1); // see R19
          end
          dual_buck_pkg::ST_BLANK: begin
            // Comparator ignored here: turn-on noise must not end the cycle
            if (cnt_reg[i] == 16'h0000) st_reg[i] <= dual_buck_pkg::ST_SENSE;
            else cnt_reg[i] <= cnt_reg[i] - 1'b1; // see R5
          end
          dual_buck_pkg::ST_SENSE: if (peak_hit_i[i] || !act[i]) begin
            st_reg[i]  <= dual_buck_pkg::ST_OFF; // see R6
            cnt_reg[i] <= off_len - 1'b1;
          end
          dual_buck_pkg::ST_OFF: begin
            if (cnt_reg[i] != 16'h0000) cnt_reg[i] <= cnt_reg[i] - 1'b1;
            else if (act[i]) begin
              st_reg[i]  <= dual_buck_pkg::ST_BLANK; // see R4
              cnt_reg[i] <= 16'(BLANK_CYC - 1);
            end else st_reg[i] <= dual_buck_pkg::ST_IDLE;
          end
          default: st_reg[i] <= dual_buck_pkg::ST_IDLE;
        endcase
      end
    end

    // Start-up, idle and trigger bookkeeping; sets win over clears
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        act_q_reg[i]    <= 1'b0;
        started_reg[i]  <= 1'b0;
        uv_pend_reg[i]  <= 1'b0;
        clr_pend_reg[i] <= 1'b0;
        su_cnt_reg[i]   <= 16'h0000;
        idle_cnt_reg[i] <= 16'h0000;
        latched_reg[i]  <= 1'b0;
      end else if (ce_i) begin
        act_q_reg[i] <= act[i];
        if (trig[i]) started_reg[i] <= 1'b1;
        uv_pend_reg[i]  <= vs_uv_i || (uv_pend_reg[i] && !trig[i]);
        clr_pend_reg[i] <= (latch_clr[i] && latched_reg[i]) ||
                           (clr_pend_reg[i] && !trig[i]);
        if (trig[i]) su_cnt_reg[i] <= 16'(STARTUP_CYC); // see R20
        else if (su_act[i]) su_cnt_reg[i] <= su_cnt_reg[i] - 1'b1;
        if (act[i]) idle_cnt_reg[i] <= 16'h0000;
        else if (!idle_long) idle_cnt_reg[i] <= idle_cnt_reg[i] + 1'b1;
        // Short only counts outside start-up; the latch stops the channel
        latched_reg[i] <= (short_det_i[i] && act[i] && !su_act[i] &&
                           !trig[i]) || (latched_reg[i] && !latch_clr[i]);
      end // see R11
    end

    a_start_on: assert property (@(posedge sys_clk_i) // see R4
      disable iff (rst_i || !ce_i)
      st_reg[i] == dual_buck_pkg::ST_IDLE && act[i] |=> switch_on_o[i])
      else $error("switch not turned on at period start");
    a_blank_hold: assert property (@(posedge sys_clk_i) // see R5
      disable iff (rst_i || !ce_i)
      $rose(switch_on_o[i]) |-> switch_on_o[i][*3])
      else $error("switch released inside blank time");
    a_peak_off: assert property (@(posedge sys_clk_i) // see R6
      disable iff (rst_i || !ce_i)
      st_reg[i] == dual_buck_pkg::ST_SENSE && peak_hit_i[i]
      |=> !switch_on_o[i])
      else $error("switch still on after peak reached");
    a_off_min: assert property (@(posedge sys_clk_i) // see R9
      disable iff (rst_i || !ce_i)
      $fell(switch_on_o[i]) |-> !switch_on_o[i][*3])
      else $error("off time shorter than minimum");
    a_half_mode: assert property (@(posedge sys_clk_i) // see R2
      disable iff (rst_i)
      switch_on_o[i] |-> half_en_o[i][1] == ch_cfg_o[i].low_rds &&
      half_en_o[i][0])
      else $error("power stage halves wrong for mode");
    a_short_mask: assert property (@(posedge sys_clk_i) // see R11
      disable iff (rst_i || !ce_i)
      su_act[i] && !latched_reg[i] |=> !latched_reg[i])
      else $error("short latched during start-up");
    a_startup_trig: assert property (@(posedge sys_clk_i) // see R12
      disable iff (rst_i || !ce_i)
      trig[i] |=> su_act[i] && su_cnt_reg[i] == 16'(STARTUP_CYC))
      else $error("start-up phase not applied");
    a_first_act: assert property (@(posedge sys_clk_i) // see R12
      disable iff (rst_i || !ce_i)
      act[i] && !act_q_reg[i] && !started_reg[i] |=> su_act[i])
      else $error("first activation without start-up");
    c_startup: cover property (@(posedge sys_clk_i) $rose(su_act[i]));
    c_latched: cover property (@(posedge sys_clk_i) $rose(latched_reg[i]));
    c_off: cover property (@(posedge sys_clk_i)
      st_reg[i] == dual_buck_pkg::ST_SENSE && peak_hit_i[i]);
  end

  a_bresp_hold: assert property (@(posedge sys_clk_i)
    disable iff (rst_i || !ce_i)
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");

endmodule // dual_buck_ctrl

// *** rtl/dual_buck_pkg.sv ***
package dual_buck_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] ADDR_CR1    = 8'h00;
  localparam logic [7:0] ADDR_CR2    = 8'h04;
  localparam logic [7:0] ADDR_CR3    = 8'h08;
  localparam logic [7:0] ADDR_CTL    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SPI_RX = 8'h14;

  // Implemented bits per register; the rest read as zero
  localparam logic [31:0] CR1_MASK = 32'h0000000c;
  localparam logic [31:0] CR2_MASK = 32'h00fffff0;
  localparam logic [31:0] CR3_MASK = 32'h0000003c;
  localparam logic [31:0] CTL_MASK = 32'h03ff0007;
  localparam logic [31:0] REG_RST  = 32'h00000000;

  // Field positions, index 0 is the first buck, 1 the second
  localparam int RDS_POS [2]   = '{2, 3};
  localparam int PEAK_LSB [2]  = '{18, 12};
  localparam int RIPL_LSB [2]  = '{8, 4};
  localparam int WIN_LSB [2]   = '{4, 2};
  localparam int CTL_EN_LSB    = 0;
  localparam int CTL_DSEL_POS  = 2;
  localparam int CTL_DUTY_LSB  = 16;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // Timing, figures in ns, cycle counts derived from the clock period
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_NS      = 300;
  localparam int TOFF_MIN_NS   = 300;
  localparam int TOFF_STEP_NS  = 500;
  localparam int STARTUP_NS    = 1000000;
  localparam int IDLE_DLY_NS   = 2000000;
  localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_MIN_CYC  =
    (TOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOFF_STEP_CYC = TOFF_STEP_NS / CLK_PERIOD_NS;
  localparam int STARTUP_CYC   = STARTUP_NS / CLK_PERIOD_NS;
  localparam int IDLE_CYC      = IDLE_DLY_NS / CLK_PERIOD_NS;
  localparam int PWM_BITS      = 10;

  ////////////////////////////////////////////////////////////////////////
  // Per-channel switching state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BLANK = 2'b01,
    ST_SENSE = 2'b10,
    ST_OFF   = 2'b11
  } sw_state_t;

  // Per-channel settings handed to the analog front end
  typedef struct packed {
    logic [5:0] peak_current_target;
    logic [3:0] ripple_constant;
    logic [1:0] vin_window;
    logic       low_rds;
  } ch_cfg_t;

endpackage

// *** tb/power_stage_model.sv ***
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
// Far-side power stage, current ramps while each switch is closed
module power_stage_model #(
  parameter int DLY [2] = '{1, 6}
) (
  input  wire logic       sys_clk_i,
  input  wire logic [1:0] switch_on_i,
  input  wire logic [1:0] short_req_i,
  output logic      [1:0] peak_hit_o,
  output logic      [1:0] short_det_o
);
  int on_cnt [2];

  // Cycles each switch has been on, cleared when it opens
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      on_cnt[i] <= switch_on_i[i] ? on_cnt[i] + 1 : 0;
    end
  end

  // No current flows while open, so no peak level then
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      peak_hit_o[i] = switch_on_i[i] && (on_cnt[i] >= DLY[i]);
    end
  end

  // A shorted output shows whether or not the switch runs
  assign short_det_o = short_req_i;
endmodule // power_stage_model

// *** tb/tb_dual_buck_peak_current_control.sv ***
`timescale 1ns/10ps

module tb_dual_buck_peak_current_control;
  localparam int BLANK = 3;
  localparam int TMIN  = 3;
  localparam int STEP  = 5;
  localparam int DLY1  = 6;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  strb = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sdo;
  logic        vs_uv = 1'b0, ddim = 1'b1, ce = 1'b1, dclk = 1'b0;
  logic [1:0]  bresp, rresp, peak, sdet, sw, latched, su, sreq = 2'b00;
  logic [1:0][1:0] half;
  dual_buck_pkg::ch_cfg_t [1:0] cfg;
  int          fail_count = 0, cmp_count = 0;

  dual_buck_ctrl #(.BLANK_CYC(BLANK), .TOFF_MIN_CYC(TMIN),
    .TOFF_STEP_CYC(STEP), .STARTUP_CYC(20), .IDLE_CYC(40)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .peak_hit_i(peak), .short_det_i(sdet), .vs_uv_i(vs_uv),
    .direct_dim_i(ddim), .dimming_clock_input_i(dclk),
    .serial_select_low_i(1'b1), .serial_clk_i(1'b0), .serial_data_i(1'b0),
    .serial_data_o(sdo), .switch_on_o(sw), .half_en_o(half), .ch_cfg_o(cfg),
    .short_latched_o(latched), .startup_o(su));

  power_stage_model #(.DLY('{1, DLY1})) i_stage (.sys_clk_i(sys_clk_i),
    .switch_on_i(sw), .short_req_i(sreq), .peak_hit_o(peak),
    .short_det_o(sdet));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master, each item dropped on the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_i);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  // One fresh switching cycle, in clock samples
  task automatic measure(input int ch, output int on_c, off_c,
                         output logic [1:0] h);
    int n = 0;
    {on_c, off_c} = 0;
    while (sw[ch] !== 1'b0 && n < 300) begin @(posedge sys_clk_i); n++; end
    while (sw[ch] !== 1'b1 && n < 300) begin @(posedge sys_clk_i); n++; end
    h = half[ch];
    while (sw[ch] === 1'b1 && on_c < 300) begin
      @(posedge sys_clk_i);
      on_c++;
    end
    while (sw[ch] === 1'b0 && off_c < 300) begin
      @(posedge sys_clk_i);
      off_c++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [31:0] d, cr2;
    logic [1:0]  r;
    cr2 = (32'h2a << 18) | (32'h15 << 12) | (32'h2 << 8) | (32'h1 << 4);
    axi_rd(dual_buck_pkg::ADDR_CR2, d, r);
    check("cr2 reset", d, dual_buck_pkg::REG_RST);
    axi_wr(dual_buck_pkg::ADDR_CR1, 32'hfffffff7, r);
    strb <= 4'h2;
    axi_wr(dual_buck_pkg::ADDR_CR1, 32'h00000008, r); // Lane not enabled
    strb <= 4'hf;
    axi_wr(dual_buck_pkg::ADDR_CR2, cr2 | 32'hff00000f, r);
    axi_wr(dual_buck_pkg::ADDR_CR3, 32'h00000024, r);
    check("cr3 bresp", r, dual_buck_pkg::RESP_OKAY);
    axi_rd(dual_buck_pkg::ADDR_CR1, d, r);
    check("cr1 readback", d, 32'h00000004);
    axi_rd(dual_buck_pkg::ADDR_CR2, d, r);
    check("cr2 readback", d, cr2);
    check("peak ch0", cfg[0].peak_current_target, 32'h2a);
    check("peak ch1", cfg[1].peak_current_target, 32'h15);
    check("ripple ch0", cfg[0].ripple_constant, 32'h2);
    check("ripple ch1", cfg[1].ripple_constant, 32'h1);
    check("window", {cfg[0].vin_window, cfg[1].vin_window}, 32'h9);
    check("low rds", {cfg[0].low_rds, cfg[1].low_rds}, 32'h2);
    axi_wr(8'h18, 32'h00000001, r);
    check("unmapped bresp", r, dual_buck_pkg::RESP_SLVERR);
    axi_rd(8'h18, d, r);
    check("unmapped rresp", r, dual_buck_pkg::RESP_SLVERR);
    check("unmapped rdata", d, 32'h0);
  endtask

  task automatic t_switch();
    int          on_c, off_c;
    logic [1:0]  h, r;
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00000003, r);
    repeat (3) @(posedge sys_clk_i);
    check("first start-up", su, 32'h3);
    measure(0, on_c, off_c, h);
    check("early peak on time", on_c, BLANK + 1);
    check("ch0 off time", off_c, TMIN + 2 * STEP);
    check("ch0 halves", h, 32'h3);
    measure(1, on_c, off_c, h);
    check("late peak on time", on_c, DLY1 + 1);
    check("ch1 off time", off_c, TMIN + STEP);
    check("ch1 halves", h, 32'h1);
    axi_wr(dual_buck_pkg::ADDR_CR2, 32'h0, r);
    measure(0, on_c, off_c, h);
    check("minimum off time", off_c, TMIN);
  endtask

  task automatic t_startup();
    logic [1:0] r;
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00000002, r);
    repeat (5) @(posedge sys_clk_i);
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00000003, r);
    repeat (3) @(posedge sys_clk_i);
    check("short idle no start-up", su[0], 32'h0);
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00000002, r);
    repeat (60) @(posedge sys_clk_i);
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00000003, r);
    sreq <= 2'b01;
    repeat (5) @(posedge sys_clk_i);
    check("long idle start-up", su[0], 32'h1);
    check("short masked", latched, 32'h0);
    repeat (30) @(posedge sys_clk_i);
    check("short latched", {latched, sw[0]}, 32'h2);
    sreq <= 2'b00;
    axi_wr(dual_buck_pkg::ADDR_STATUS, 32'h00000001, r);
    repeat (3) @(posedge sys_clk_i);
    check("clear restarts", {latched, su[0]}, 32'h1);
    repeat (30) @(posedge sys_clk_i);
    vs_uv <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    vs_uv <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check("undervoltage start-up", su, 32'h3);
  endtask

  task automatic t_dim();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(dual_buck_pkg::ADDR_CTL, 32'h00020005, r);
    ce <= 1'b0;
    repeat (4) @(posedge sys_clk_i) dclk <= ~dclk;
    ce <= 1'b1;
    axi_rd(dual_buck_pkg::ADDR_STATUS, d, r);
    check("ce freeze", d[6], 32'h1);
    repeat (4) @(posedge sys_clk_i) dclk <= ~dclk;
    axi_rd(dual_buck_pkg::ADDR_STATUS, d, r);
    check("pwm dim", d[6], 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog well past the few hundred cycles
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #3000000;
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_switch();
    t_startup();
    t_dim();
    stop_test();
  end
endmodule // tb_dual_buck_peak_current_control
